// [lpm_pkg.sv]
package lpm_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 16;
  localparam int unsigned SEL_W  = 3;

  // Printed offsets are word indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_INDICATOR_CTRL = 16'h0462;
  localparam logic [ADDR_W-1:0] IDX_CLOCK_CTRL     = 16'h0463;
  localparam logic [ADDR_W-1:0] IDX_BOOT_STATUS    = 16'h0467;
  localparam logic [ADDR_W-1:0] ADDR_INDICATOR_CTRL = ADDR_W'(IDX_INDICATOR_CTRL * 4);
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_CTRL     = ADDR_W'(IDX_CLOCK_CTRL * 4);
  localparam logic [ADDR_W-1:0] ADDR_BOOT_STATUS    = ADDR_W'(IDX_BOOT_STATUS * 4);

  localparam logic [REG_W-1:0] RST_INDICATOR_CTRL  = 16'h0000;
  localparam logic [REG_W-1:0] RST_CLOCK_CTRL      = 16'h0001;
  localparam logic [REG_W-1:0] MASK_INDICATOR_CTRL = 16'h7777;
  localparam logic [REG_W-1:0] MASK_CLOCK_CTRL     = 16'h00F7;

  // Field positions
  localparam int unsigned POS_A_SEL     = 0;
  localparam int unsigned POS_A_CLK     = 4;
  localparam int unsigned POS_B_SEL     = 8;
  localparam int unsigned POS_B_CLK     = 12;
  localparam int unsigned POS_C_SEL     = 0;
  localparam int unsigned POS_C_CLK     = 4;
  localparam int unsigned POS_AUTO      = 14;
  localparam int unsigned POS_ADDR02    = 12;
  localparam int unsigned POS_ADDR13    = 10;
  localparam int unsigned POS_ROLE      = 8;
  localparam int unsigned POS_HOST_TEST = 6;

  typedef enum logic [2:0] {
    LPM_SRC_OWN   = 3'b000,
    LPM_SRC_CLOCK = 3'b001,
    LPM_SRC_WAKE  = 3'b010,
    LPM_SRC_UV    = 3'b011,
    LPM_SRC_TS_TX = 3'b100,
    LPM_SRC_TS_RX = 3'b101,
    LPM_SRC_LOW   = 3'b110,
    LPM_SRC_HIGH  = 3'b111
  } lpm_src_t;

  localparam logic [1:0] MODE_1 = 2'h0;
  localparam logic [1:0] MODE_4 = 2'h3;
  localparam logic [3:0] CLKSRC_LINE = 4'h1;
endpackage

// [lpm_top.sv]
module lpm_pin_sel
  import lpm_pkg::*;
#(
  parameter int unsigned CSW = 3
)(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic [SEL_W-1:0] sel,
  input  wire logic [CSW-1:0] clk_sel,
  input  wire logic           own_func,
  input  wire logic           crystal_input_clock,
  input  wire logic           transmit_line_clock,
  input  wire logic           wake_indication,
  input  wire logic           undervoltage,
  input  wire logic           ts_transmit,
  input  wire logic           ts_receive,
  output logic                pin_ff
);
  // Codes other than one fall back to the crystal clock
  wire use_line  = (clk_sel == CSW'(CLKSRC_LINE));
  wire clk_route = use_line ? transmit_line_clock : crystal_input_clock;
  logic nxt_pin;

  always_comb
  begin
    case (lpm_src_t'(sel))
      LPM_SRC_OWN:   nxt_pin = own_func;
      LPM_SRC_CLOCK: nxt_pin = clk_route;
      LPM_SRC_WAKE:  nxt_pin = wake_indication;
      LPM_SRC_UV:    nxt_pin = undervoltage;
      LPM_SRC_TS_TX: nxt_pin = ts_transmit;
      LPM_SRC_TS_RX: nxt_pin = ts_receive;
      LPM_SRC_LOW:   nxt_pin = 1'b0;
      LPM_SRC_HIGH:  nxt_pin = 1'b1;
      default:       nxt_pin = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_ff <= 1'b0;
    else
      pin_ff <= nxt_pin;
  end
endmodule

module lpm_top
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [lpm_pkg::ADDR_W-1:0] paddr,
  input  wire logic [lpm_pkg::DATA_W-1:0] pwdata,
  output logic      [lpm_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       indicator_func_a,
  input  wire logic                       indicator_func_b,
  input  wire logic                       indicator_func_c,
  input  wire logic                       crystal_input_clock,
  input  wire logic                       transmit_line_clock,
  input  wire logic                       wake_indication,
  input  wire logic                       undervoltage,
  input  wire logic                       ts_transmit,
  input  wire logic                       ts_receive,
  input  wire logic                       strap_autonomous_en,
  input  wire logic                       strap_master_role,
  input  wire logic [3:0]                 strap_station_address,
  input  wire logic                       strap_host_interface_mode0,
  input  wire logic                       strap_test_mode0,
  output logic                            indicator_pin_a,
  output logic                            indicator_pin_b,
  output logic                            clock_output_pin
);
  import lpm_pkg::*;

  logic [REG_W-1:0]  indicator_ctrl_ff;
  logic [REG_W-1:0]  clock_ctrl_ff;
  logic [REG_W-1:0]  boot_status_ff;
  logic              strap_done_ff;
  logic [DATA_W-1:0] prdata_ff;
  logic              pready_ff;
  logic              pslverr_ff;

  wire hit_ind   = (paddr == ADDR_INDICATOR_CTRL);
  wire hit_clk   = (paddr == ADDR_CLOCK_CTRL);
  wire hit_boot  = (paddr == ADDR_BOOT_STATUS);
  wire mapped    = hit_ind | hit_clk | hit_boot;
  wire setup     = psel & ~penable;
  wire wr_commit = psel & penable & pready_ff & pwrite;

  wire [REG_W-1:0] wdata16  = pwdata[REG_W-1:0];
  wire [REG_W-1:0] nxt_ind  = wdata16 & MASK_INDICATOR_CTRL;
  wire [REG_W-1:0] nxt_clk  = wdata16 & MASK_CLOCK_CTRL;
  wire [REG_W-1:0] rd_sel   = hit_ind ? indicator_ctrl_ff :
                              hit_clk ? clock_ctrl_ff :
                              hit_boot ? boot_status_ff : '0;
  wire [DATA_W-1:0] nxt_prdata  = (setup & ~pwrite) ? {{(DATA_W-REG_W){1'b0}}, rd_sel} : '0;
  wire              nxt_pslverr = setup & ~mapped;

  // Pair codes count modes: (0,0)=1, (0,1)=2, (1,1)=3, (1,0)=4
  function automatic logic [1:0] pair_code(input logic first, input logic second);
    pair_code = {first, first ^ second};
  endfunction

  wire [1:0] auto_code = strap_autonomous_en ? MODE_1 : MODE_4;
  wire [1:0] role_code = strap_master_role ? MODE_4 : MODE_1;
  wire [1:0] a02_code  = pair_code(strap_station_address[0], strap_station_address[2]);
  wire [1:0] a13_code  = pair_code(strap_station_address[1], strap_station_address[3]);
  wire [1:0] ht_code   = pair_code(strap_host_interface_mode0, strap_test_mode0);
  // Lowest receive field relies on the board strapping mode 1, which reads 00
  wire [REG_W-1:0] nxt_boot = REG_W'((REG_W'(auto_code) << POS_AUTO) | (REG_W'(a02_code) << POS_ADDR02) |
                                     (REG_W'(a13_code) << POS_ADDR13) | (REG_W'(role_code) << POS_ROLE) |
                                     (REG_W'(ht_code) << POS_HOST_TEST));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff  <= setup;
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Status register has no write path at all
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      indicator_ctrl_ff <= RST_INDICATOR_CTRL;
      clock_ctrl_ff     <= RST_CLOCK_CTRL;
    end
    else
    begin
      if (wr_commit && hit_ind)
        indicator_ctrl_ff <= nxt_ind;
      if (wr_commit && hit_clk)
        clock_ctrl_ff <= nxt_clk;
    end
  end

  // Straps are caught on the first edge after release, never under reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_done_ff  <= 1'b0;
      boot_status_ff <= '0;
    end
    else if (!strap_done_ff)
    begin
      strap_done_ff  <= 1'b1;
      boot_status_ff <= nxt_boot;
    end
  end

  lpm_pin_sel #(.CSW(3)) u_pin_a (
    .pclk                (pclk),
    .presetn             (presetn),
    .sel                 (indicator_ctrl_ff[POS_A_SEL +: SEL_W]),
    .clk_sel             (indicator_ctrl_ff[POS_A_CLK +: 3]),
    .own_func            (indicator_func_a),
    .crystal_input_clock (crystal_input_clock),
    .transmit_line_clock (transmit_line_clock),
    .wake_indication     (wake_indication),
    .undervoltage        (undervoltage),
    .ts_transmit         (ts_transmit),
    .ts_receive          (ts_receive),
    .pin_ff              (indicator_pin_a)
  );

  lpm_pin_sel #(.CSW(3)) u_pin_b (
    .pclk                (pclk),
    .presetn             (presetn),
    .sel                 (indicator_ctrl_ff[POS_B_SEL +: SEL_W]),
    .clk_sel             (indicator_ctrl_ff[POS_B_CLK +: 3]),
    .own_func            (indicator_func_b),
    .crystal_input_clock (crystal_input_clock),
    .transmit_line_clock (transmit_line_clock),
    .wake_indication     (wake_indication),
    .undervoltage        (undervoltage),
    .ts_transmit         (ts_transmit),
    .ts_receive          (ts_receive),
    .pin_ff              (indicator_pin_b)
  );

  // Clock pin's own function is the third indicator
  lpm_pin_sel #(.CSW(4)) u_pin_clk (
    .pclk                (pclk),
    .presetn             (presetn),
    .sel                 (clock_ctrl_ff[POS_C_SEL +: SEL_W]),
    .clk_sel             (clock_ctrl_ff[POS_C_CLK +: 4]),
    .own_func            (indicator_func_c),
    .crystal_input_clock (crystal_input_clock),
    .transmit_line_clock (transmit_line_clock),
    .wake_indication     (wake_indication),
    .undervoltage        (undervoltage),
    .ts_transmit         (ts_transmit),
    .ts_receive          (ts_receive),
    .pin_ff              (clock_output_pin)
  );

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
endmodule

// [lpm_properties.sv]
module lpm_chk
  import lpm_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        strap_autonomous_en,
  input wire logic        strap_master_role,
  input wire logic [3:0]  strap_station_address,
  input wire logic        strap_host_interface_mode0,
  input wire logic        strap_test_mode0
);
  logic       arm_ff;
  logic [9:0] st_ff;
  wire        rd    = psel & penable & pready & !pwrite;
  wire        rd_st = rd & (paddr == ADDR_BOOT_STATUS);
  wire        rd_ck = rd & (paddr == ADDR_CLOCK_CTRL);
  wire  [3:0] adr   = strap_station_address;
  wire        hm    = strap_host_interface_mode0;
  // Shadow of the straps taken on the first edge out of reset; later strap moves must not show
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      arm_ff <= 1'h1;
      st_ff  <= 10'h000;
    end
    else
    begin
      arm_ff <= 1'h0;
      if (arm_ff)
        st_ff <= {{2{!strap_autonomous_en}}, adr[0], adr[0] ^ adr[2], adr[1], adr[1] ^ adr[3],
                  {2{strap_master_role}}, hm, hm ^ strap_test_mode0};
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  property p_ready; s_setup |=> pready; endproperty
  property p_auto; rd_st |-> prdata[15:14] == st_ff[9:8]; endproperty
  property p_adr02; rd_st |-> prdata[13:12] == st_ff[7:6]; endproperty
  property p_adr13; rd_st |-> prdata[11:10] == st_ff[5:4]; endproperty
  property p_role; rd_st |-> prdata[9:8] == st_ff[3:2]; endproperty
  property p_host; rd_st |-> prdata[7:6] == st_ff[1:0]; endproperty
  property p_zero; rd_st |-> prdata[31:16] == 16'h0000 && prdata[5:0] == 6'h00; endproperty
  property p_rsvd; rd_ck |-> prdata[31:8] == 24'h000000 && !prdata[3]; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  a_auto: assert property (p_auto) else $error("auto mode");
  a_adr02: assert property (p_adr02) else $error("addr 0 2");
  a_adr13: assert property (p_adr13) else $error("addr 1 3");
  a_role: assert property (p_role) else $error("role mode");
  a_host: assert property (p_host) else $error("host mode");
  a_zero: assert property (p_zero) else $error("status spare");
  a_rsvd: assert property (p_rsvd) else $error("ctrl spare");
endmodule

bind lpm_top lpm_chk lpm_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .strap_autonomous_en, .strap_master_role, .strap_station_address, .strap_host_interface_mode0, .strap_test_mode0);

// [lpm_board.sv]
module lpm_board (
  input  wire logic [7:0] cfg,
  output logic      [7:0] strap
);
  // Fixed resistors; the lowest receive data strap sits in mode 1 and has no input
  assign strap = cfg;
endmodule

// [tb_led_clock_output_pin_pin_mux_strap_status.sv]
module tb_led_clock_output_pin_pin_mux_strap_status
  import lpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [15:0] ind; logic [15:0] ck; logic [6:0] src; logic [2:0] pin;} lpm_row_t;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [6:0]  src = 7'h00;
  logic [7:0]  cfg = 8'h00;
  // Crystal high and line low at first, swapped later, so a wrong route cannot hide behind equal levels
  logic [1:0]  clks = 2'h2;
  logic [31:0] prdata, rdata;
  logic        pready, pslverr, rerr;
  wire  [7:0]  strap;
  wire  [2:0]  pins;
  int          fail_count = 0;
  int          check_count = 0;
  lpm_row_t    rows [10] = '{'{16'h0700, 16'h0000, 7'h40, 3'h6}, '{16'h0611, 16'h0011, 7'h30, 3'h0},
    '{16'h0502, 16'h0002, 7'h09, 3'h7}, '{16'h0403, 16'h0003, 7'h7A, 3'h2}, '{16'h0304, 16'h0004, 7'h79, 3'h0},
    '{16'h0205, 16'h0005, 7'h27, 3'h5}, '{16'h1106, 16'h0006, 7'h7F, 3'h0}, '{16'h0007, 16'h0007, 7'h00, 3'h5},
    '{16'hFFFF, 16'hFFFF, 7'h00, 3'h7}, '{16'h0101, 16'h0001, 7'h00, 3'h7}};
  lpm_top lpm_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .indicator_func_a(src[6]), .indicator_func_b(src[5]), .indicator_func_c(src[4]), .crystal_input_clock(clks[1]),
    .transmit_line_clock(clks[0]), .wake_indication(src[3]), .undervoltage(src[2]), .ts_transmit(src[1]),
    .ts_receive(src[0]), .strap_autonomous_en(strap[7]), .strap_master_role(strap[6]),
    .strap_station_address(strap[5:2]), .strap_host_interface_mode0(strap[1]), .strap_test_mode0(strap[0]),
    .indicator_pin_a(pins[2]), .indicator_pin_b(pins[1]), .clock_output_pin(pins[0]));
  lpm_board lpm_board_inst (.cfg, .strap);
  always #20 pclk = ~pclk;
  task automatic test_done;
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk);
    while (pready !== 1'h1 && ++n < 20);
    if (n == 20)
    begin
      fail_count++;
      $display("mismatch at %0t: no ready", $time);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Straps move two edges after release, so only a latch taken at release survives
  task automatic rst(input logic [7:0] c);
    presetn <= 1'h0;
    cfg <= c;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    cfg <= ~c;
  endtask
  initial
  begin
    rst(8'h9A);
    apb(1'h0, ADDR_BOOT_STATUS, 16'h0000);
    chk(rdata, 32'h1CC0);
    chk({31'h0, rerr}, 32'h0);
    apb(1'h1, ADDR_BOOT_STATUS, 16'hFFFF);
    apb(1'h0, ADDR_BOOT_STATUS, 16'h0000);
    chk(rdata, 32'h1CC0);
    apb(1'h0, ADDR_INDICATOR_CTRL, 16'h0000);
    chk(rdata, 32'h0000);
    apb(1'h0, ADDR_CLOCK_CTRL, 16'h0000);
    chk(rdata, 32'h0001);
    chk({29'h0, pins}, 32'h1);
    apb(1'h1, 16'h0004, 16'hFFFF);
    apb(1'h0, 16'h0004, 16'h0000);
    chk({rdata[30:0], rerr}, 32'h1);
    foreach (rows[i])
    begin
      src <= rows[i].src;
      apb(1'h1, ADDR_INDICATOR_CTRL, rows[i].ind);
      apb(1'h1, ADDR_CLOCK_CTRL, rows[i].ck);
      repeat (2) @(posedge pclk);
      chk({29'h0, pins}, {29'h0, rows[i].pin});
      apb(1'h0, ADDR_INDICATOR_CTRL, 16'h0000);
      chk(rdata, {16'h0000, rows[i].ind & MASK_INDICATOR_CTRL});
      apb(1'h0, ADDR_CLOCK_CTRL, 16'h0000);
      chk(rdata, {16'h0000, rows[i].ck & MASK_CLOCK_CTRL});
    end
    clks <= 2'h1;
    apb(1'h1, ADDR_INDICATOR_CTRL, 16'h1111);
    apb(1'h1, ADDR_CLOCK_CTRL, 16'h0011);
    repeat (2) @(posedge pclk);
    chk({29'h0, pins}, 32'h7);
    apb(1'h1, ADDR_INDICATOR_CTRL, 16'h0101);
    apb(1'h1, ADDR_CLOCK_CTRL, 16'h0001);
    repeat (2) @(posedge pclk);
    chk({29'h0, pins}, 32'h0);
    rst(8'h65);
    apb(1'h0, ADDR_BOOT_STATUS, 16'h0000);
    chk(rdata, 32'hF740);
    apb(1'h0, ADDR_INDICATOR_CTRL, 16'h0000);
    chk(rdata, 32'h0000);
    test_done;
  end
  initial
  begin
    #50000;
    fail_count++;
    $display("mismatch at %0t: timeout", $time);
    test_done;
  end
endmodule
